// ---- core/dhp_chan.sv ----
`default_nettype none
module dhp_chan
  import dhp_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // register access
  dhp_chan_if.chan_side bus
);
  logic [7:0] mode_reg [2];
  logic       mode_ptr;
  logic [7:0] status_reg;
  logic [2:0] cmd_code;
  logic       wr_mode;
  logic       wr_cmd;

  // local decode
  assign wr_mode = bus.wr && (bus.sel == LOC_MODE);
  assign wr_cmd = bus.wr && (bus.sel == LOC_CMD);
  assign cmd_code = bus.wdata[CMD_CODE_MSB:CMD_CODE_LSB];

  // read selection; command select reads back as zero
  assign bus.rdata = (bus.sel == LOC_MODE) ? mode_reg[mode_ptr] :
                     (bus.sel == LOC_STAT) ? status_reg :
                     (bus.sel == LOC_DATA) ? bus.rx_data : BYTE_CLEAR;

  // status follows the channel; reset clears it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      status_reg <= BYTE_CLEAR; // [RULE7]
    else if (bus.clk_en)
      status_reg <= bus.status_in;
  end

  // mode pair: any access moves the pointer to the second register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg[0] <= BYTE_CLEAR;
      mode_reg[1] <= BYTE_CLEAR;
      mode_ptr    <= 1'b0; // [RULE10]
    end
    else if (bus.clk_en)
    begin
      if (wr_mode)
        mode_reg[mode_ptr] <= bus.wdata; // [RULE5]
      if (wr_cmd && cmd_code == CMD_RESET_PTR)
        mode_ptr <= 1'b0;
      else if (wr_mode || (bus.rd_start && bus.sel == LOC_MODE))
        mode_ptr <= 1'b1;
    end
  end

  // enables and transmit holding; disable wins over enable in one byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus.tx_en   <= 1'b0; // [RULE9]
      bus.rx_en   <= 1'b0;
      bus.tx_data <= BYTE_CLEAR;
      bus.tx_load <= 1'b0;
    end
    else if (bus.clk_en)
    begin
      bus.tx_load <= bus.wr && (bus.sel == LOC_DATA);
      if (bus.wr && bus.sel == LOC_DATA)
        bus.tx_data <= bus.wdata;
      if (wr_cmd && bus.wdata[CMD_TX_DIS])
        bus.tx_en <= 1'b0;
      else if (wr_cmd && bus.wdata[CMD_TX_EN])
        bus.tx_en <= 1'b1;
      if (wr_cmd && bus.wdata[CMD_RX_DIS])
        bus.rx_en <= 1'b0;
      else if (wr_cmd && bus.wdata[CMD_RX_EN])
        bus.rx_en <= 1'b1;
    end
  end

  a_ptr_reset: assert property (@(posedge sys_clk) // [RULE10]
    $fell(rst) |-> (mode_ptr == 1'b0))
    else $error("mode pointer not at first register after reset");
endmodule
`default_nettype wire

// ---- core/dhp_chan_if.sv ----
`default_nettype none
interface dhp_chan_if;
  logic       clk_en;
  logic       wr;        // one-cycle write pulse
  logic       rd_start;  // one-cycle pulse at read start
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] status_in;
  logic [7:0] rx_data;
  logic [7:0] rdata;
  logic [7:0] tx_data;
  logic       tx_load;
  logic       tx_en;
  logic       rx_en;

  modport port_side (output clk_en, wr, rd_start, sel, wdata, status_in,
                     rx_data, input rdata, tx_data, tx_load, tx_en, rx_en);
  modport chan_side (input clk_en, wr, rd_start, sel, wdata, status_in,
                     rx_data, output rdata, tx_data, tx_load, tx_en, rx_en);
endinterface
`default_nettype wire

// ---- core/dhp_host_port.sv ----
// Overview of operation
// [RULE1] with chip select low, strobes and selects steer register transfers
// [RULE2] with chip select high the data lines are never driven
// [RULE3] write data is latched into the register at write strobe rising edge
// [RULE4] read strobe low with chip select low drives register onto the bus
// [RULE5] the four select lines choose the register; host holds them stable
// [RULE6] data bus carries commands, data, status; line zero is the LSB
// [RULE7] reset clears channel status, mask, interrupt status, port registers
// [RULE8] reset drives all output port pins high and halts the timer
// [RULE9] reset makes both channels inactive with serial outputs at mark
// [RULE10] reset clears test mode and points mode pointer at first register
// [RULE11] interrupt line pulled low while any masked condition is true
// [RULE12] host never asserts both strobes together under chip select
`default_nettype none
module dhp_host_port
  import dhp_pkg::*;
(
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // host bus pins
  input  wire logic       chip_select_low,
  input  wire logic       write_strobe_low,
  input  wire logic       read_strobe_low,
  input  wire logic [3:0] register_select_lines,
  input  wire logic [7:0] host_data_lines_in,
  output logic      [7:0] host_data_lines_out,
  output logic            host_data_lines_oe_low,
  // open-drain interrupt
  output logic            interrupt_request_low_out,
  output logic            interrupt_request_low_oe_low,
  input  wire logic [7:0] interrupt_conditions,
  // channel side
  input  wire logic [7:0] status_first_channel,
  input  wire logic [7:0] status_second_channel,
  input  wire logic [7:0] rx_data_first_channel,
  input  wire logic [7:0] rx_data_second_channel,
  input  wire logic       tx_bit_first_channel,
  input  wire logic       tx_bit_second_channel,
  output logic      [7:0] tx_data_first_channel,
  output logic      [7:0] tx_data_second_channel,
  output logic      [1:0] chan_tx_load,
  output logic      [1:0] chan_tx_enable,
  output logic      [1:0] chan_rx_enable,
  output logic            serial_out_first_channel,
  output logic            serial_out_second_channel,
  // general port, timer, test
  output logic      [7:0] output_port_pins,
  output logic      [7:0] output_port_config,
  output logic            timer_run,
  output logic            test_mode
);
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic       cs_s;
  logic       wr_s;
  logic       rd_s;
  logic [3:0] a_s;
  logic [7:0] d_s;
  logic       wr_act;
  logic       wr_act_q;
  logic       wr_pulse;
  logic       rd_act;
  logic       rd_act_q;
  logic       rd_start;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] interrupt_mask_register;
  logic [7:0] interrupt_status_register;
  logic [7:0] output_port_register;
  logic [7:0] chan_rdata [NUM_CHAN];
  logic [7:0] rd_mux;
  logic       irq_active;

  // a select reaches a channel when its middle bit is clear
  function automatic logic is_chan(input logic [3:0] adr);
    return !adr[NONCHAN_BIT];
  endfunction

  // two-stage synchroniser on every host pin
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end
    else if (ce)
    begin
      sync_a <= {chip_select_low, write_strobe_low, read_strobe_low,
                 register_select_lines, host_data_lines_in};
      sync_b <= sync_a;
    end
  end
  assign {cs_s, wr_s, rd_s, a_s, d_s} = sync_b;

  // strobe qualification; both strobes at once is left to the host
  assign wr_act = !cs_s && !wr_s; // [RULE1] [RULE12]
  assign rd_act = !cs_s && !rd_s; // [RULE1]
  assign wr_pulse = wr_act_q && !wr_act; // [RULE3]
  assign rd_start = rd_act && !rd_act_q; // [RULE4]

  // hold the last address and data seen under the write strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_addr  <= 4'h0;
      wr_data  <= BYTE_CLEAR;
    end
    else if (ce)
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act)
      begin
        wr_addr <= a_s; // [RULE5]
        wr_data <= d_s;
      end
    end
  end

  // two channels of mode, command and status registers
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    dhp_chan_if cif ();
    logic       sel_w;
    logic       sel_r;
    assign sel_w = wr_pulse && is_chan(wr_addr) && (wr_addr[CHAN_BIT] == c);
    assign sel_r = rd_start && is_chan(a_s) && (a_s[CHAN_BIT] == c);
    assign cif.clk_en = ce;
    assign cif.wr = sel_w;
    assign cif.rd_start = sel_r;
    assign cif.sel = sel_w ? wr_addr[1:0] : a_s[1:0];
    assign cif.wdata = wr_data;
    assign cif.status_in = (c == 0) ? status_first_channel
                                    : status_second_channel;
    assign cif.rx_data = (c == 0) ? rx_data_first_channel
                                  : rx_data_second_channel;
    assign chan_rdata[c] = cif.rdata;
    assign chan_tx_load[c] = cif.tx_load;
    assign chan_tx_enable[c] = cif.tx_en;
    assign chan_rx_enable[c] = cif.rx_en;
    dhp_chan u_chan (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bus     (cif)
    );
  end
  assign tx_data_first_channel = g_chan[0].cif.tx_data;
  assign tx_data_second_channel = g_chan[1].cif.tx_data;

  // inactive transmitters sit at mark
  assign serial_out_first_channel = !chan_tx_enable[0] ? MARK
                                  : tx_bit_first_channel; // [RULE9]
  assign serial_out_second_channel = !chan_tx_enable[1] ? MARK
                                   : tx_bit_second_channel; // [RULE9]

  // read selection
  assign rd_mux = is_chan(a_s) ? chan_rdata[a_s[CHAN_BIT]] :
                  (a_s == ADR_PORT_CFG) ? output_port_config :
                  (a_s == ADR_INT)      ? interrupt_status_register :
                  (a_s == ADR_TIMER)    ? {7'h00, timer_run} :
                  (a_s == ADR_TEST)     ? {7'h00, test_mode} :
                  (a_s == ADR_PORT_SET) ? output_port_register
                                        : BYTE_CLEAR; // [RULE5]

  // read data and drive enable come from flops; one cycle behind rd_act
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      host_data_lines_out    <= BYTE_CLEAR;
      host_data_lines_oe_low <= 1'b1;
    end
    else if (ce)
    begin
      if (rd_act)
        host_data_lines_out <= rd_mux; // [RULE4] [RULE6]
      host_data_lines_oe_low <= !rd_act; // [RULE2]
    end
  end

  // global registers; port bits are set and cleared individually
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_mask_register <= BYTE_CLEAR; // [RULE7]
      interrupt_status_register <= BYTE_CLEAR;
      output_port_register <= BYTE_CLEAR;
      output_port_config <= BYTE_CLEAR;
      timer_run <= 1'b0; // [RULE8]
      test_mode <= 1'b0; // [RULE10]
    end
    else if (ce)
    begin
      interrupt_status_register <= interrupt_conditions;
      if (wr_pulse)
        case (wr_addr)
          ADR_PORT_CFG: output_port_config <= wr_data;
          ADR_INT:      interrupt_mask_register <= wr_data; // [RULE3]
          ADR_TIMER:    timer_run <= wr_data[TIMER_RUN_BIT];
          ADR_TEST:     test_mode <= wr_data[TEST_EN_BIT];
          ADR_PORT_SET:
            output_port_register <= output_port_register | wr_data;
          ADR_PORT_CLR:
            output_port_register <= output_port_register & ~wr_data;
          default:     ;
        endcase
    end
  end

  // pins are the complement, so a cleared register reads as all high
  assign output_port_pins = ~output_port_register; // [RULE8]

  // open drain: only ever pull low
  assign irq_active = |(interrupt_status_register & interrupt_mask_register);
  assign interrupt_request_low_out = 1'b0;
  assign interrupt_request_low_oe_low = !irq_active; // [RULE11]

  a_float_deselect: assert property ( // [RULE2]
    @(posedge sys_clk) disable iff (rst)
    (ce && cs_s) |=> host_data_lines_oe_low)
    else $error("data lines driven while deselected");
  a_read_drive: assert property ( // [RULE4]
    @(posedge sys_clk) disable iff (rst)
    (ce && rd_act) |=> !host_data_lines_oe_low)
    else $error("read not driven onto bus");
  a_write_select: assert property ( // [RULE1]
    @(posedge sys_clk) disable iff (rst)
    wr_pulse |-> !$past(cs_s))
    else $error("write taken without chip select");
  a_mask_write: assert property ( // [RULE3]
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_pulse && wr_addr == ADR_INT)
      |=> interrupt_mask_register == $past(wr_data))
    else $error("mask register missed written byte");
  a_port_set_bits: assert property ( // [RULE5]
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_pulse && wr_addr == ADR_PORT_SET)
      |=> (output_port_register & $past(wr_data)) == $past(wr_data))
    else $error("port set bits not applied");
  a_lsb_read: assert property ( // [RULE6]
    @(posedge sys_clk) disable iff (rst)
    (ce && rd_act && a_s == ADR_TEST)
      |=> host_data_lines_out[0] == $past(test_mode))
    else $error("test bit not on line zero");
  a_reset_clear: assert property (@(posedge sys_clk) // [RULE7]
    $fell(rst) |-> (interrupt_mask_register == BYTE_CLEAR
                    && interrupt_status_register == BYTE_CLEAR
                    && output_port_config == BYTE_CLEAR && !test_mode))
    else $error("registers not cleared by reset");
  a_reset_pins: assert property (@(posedge sys_clk) // [RULE8]
    $fell(rst) |-> (output_port_pins == PINS_IDLE && !timer_run))
    else $error("port pins or timer wrong after reset");
  a_mark_idle: assert property ( // [RULE9]
    @(posedge sys_clk) disable iff (rst)
    !chan_tx_enable[0] |-> serial_out_first_channel == MARK)
    else $error("idle transmitter not at mark");
  // a mask write in the same cycle would move the goalposts, so skip it
  a_irq_level: assert property ( // [RULE11]
    @(posedge sys_clk) disable iff (rst)
    (ce && !wr_pulse && |(interrupt_conditions & interrupt_mask_register))
      |=> !interrupt_request_low_oe_low)
    else $error("interrupt line not pulled for masked condition");
endmodule
`default_nettype wire

// ---- core/dhp_pkg.sv ----
`default_nettype none
package dhp_pkg;
  // bus geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int NUM_CHAN = 2;
  localparam int SYNC_W = 3 + ADDR_W + DATA_W;

  // register selects; channel A at 0..3, channel B at 8..B
  localparam logic [3:0] ADR_PORT_CFG = 4'h4;
  localparam logic [3:0] ADR_INT = 4'h5; // read status, write mask
  localparam logic [3:0] ADR_TIMER = 4'h6;
  localparam logic [3:0] ADR_TEST = 4'h7;
  localparam logic [3:0] ADR_PORT_SET = 4'hC; // read gives the register
  localparam logic [3:0] ADR_PORT_CLR = 4'hD;
  localparam int CHAN_BIT = 3;
  localparam int NONCHAN_BIT = 2;

  // per-channel local selects
  localparam logic [1:0] LOC_MODE = 2'h0;
  localparam logic [1:0] LOC_STAT = 2'h1;
  localparam logic [1:0] LOC_CMD = 2'h2;
  localparam logic [1:0] LOC_DATA = 2'h3;

  // command byte fields
  localparam int CMD_RX_EN = 0;
  localparam int CMD_RX_DIS = 1;
  localparam int CMD_TX_EN = 2;
  localparam int CMD_TX_DIS = 3;
  localparam int CMD_CODE_LSB = 4;
  localparam int CMD_CODE_MSB = 6;
  localparam logic [2:0] CMD_RESET_PTR = 3'h1;

  // control bit positions
  localparam int TIMER_RUN_BIT = 0;
  localparam int TEST_EN_BIT = 0;

  // reset and idle values
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam logic [7:0] PINS_IDLE = 8'hFF;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 15'h7000; // strobes high
  localparam logic MARK = 1'b1;
endpackage
`default_nettype wire

// ---- testbench/dhp_host_model.sv ----
`default_nettype none
module dhp_host_model
  import dhp_pkg::*;
(
  // clock
  input  wire logic              sys_clk,
  // host bus pins
  output var logic               chip_select_low,
  output var logic               write_strobe_low,
  output var logic               read_strobe_low,
  output var logic [ADDR_W-1:0]  register_select_lines,
  // data bus as resolved on the board
  input  wire logic [DATA_W-1:0] dev_data,
  input  wire logic              dev_oe_low,
  output logic      [DATA_W-1:0] data_bus
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [DATA_W-1:0] host_data = 8'h00;
  logic              host_drive = 1'b0;
  logic [DATA_W-1:0] last_bus = 8'h5A;

  // no pull-up here, so a floating bus shows the inverse of its last level
  assign data_bus = !dev_oe_low ? dev_data
                  : host_drive ? host_data : ~last_bus;

  // remember the last driven level
  always @(posedge sys_clk)
    if (host_drive || !dev_oe_low)
      last_bus <= data_bus;

  // idle bus at time zero
  initial
  begin
    chip_select_low       = 1'b1;
    write_strobe_low      = 1'b1;
    read_strobe_low       = 1'b1;
    register_select_lines = 4'h0;
  end

  // write: select and data set with the strobe, which is held four cycles
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    register_select_lines <= a;
    host_data             <= d;
    host_drive            <= 1'b1;
    chip_select_low       <= 1'b0;
    write_strobe_low      <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chip_select_low       <= 1'b1;
    write_strobe_low      <= 1'b1;
    // data outlives the strobe by a cycle so the last sample is clean
    @(posedge sys_clk);
    host_drive            <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask

  // read: strobe held until the device drives, bounded wait
  task automatic bus_read(input logic [3:0] a, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    register_select_lines <= a;
    chip_select_low       <= 1'b0;
    read_strobe_low       <= 1'b0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (dev_oe_low !== 1'b0 && n < 12);
    ok = (dev_oe_low === 1'b0);
    @(posedge sys_clk);
    chip_select_low       <= 1'b1;
    read_strobe_low       <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask

  // a strobe with chip select left high, which the device must ignore
  task automatic stray(input logic is_wr, input logic [3:0] a);
    @(posedge sys_clk);
    register_select_lines <= a;
    host_drive            <= is_wr;
    write_strobe_low      <= !is_wr;
    read_strobe_low       <= is_wr;
    repeat (6) @(posedge sys_clk);
    write_strobe_low      <= 1'b1;
    read_strobe_low       <= 1'b1;
    host_drive            <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/duart_host_bus_port_test.sv ----
`default_nettype none
module duart_host_bus_port_test
  import dhp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // device inputs, valued from time zero; ce is the only tied input
  logic       sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [7:0] cond = 8'h00, st_a = 8'h00, st_b = 8'h00;
  logic [7:0] rx_a = 8'h00, rx_b = 8'h00;
  logic [1:0] txb = 2'b00;
  // pins and outputs
  logic       cs_low, wr_low, rd_low, oe_low, irq_out, irq_oe_low;
  logic       trun, tmode;
  logic [3:0] sel;
  logic [7:0] bus, dout, txd_a, txd_b, opins, ocfg;
  logic [1:0] tx_load, tx_en, rx_en, so;
  // bookkeeping
  int          errors = 0, compares = 0, cycles = 0;
  int          loads[2] = '{0, 0};
  logic        prev_oe = 1'b1;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'h2EBD;

  dhp_host_port dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .chip_select_low(cs_low), .write_strobe_low(wr_low),
    .read_strobe_low(rd_low), .register_select_lines(sel),
    .host_data_lines_in(bus), .host_data_lines_out(dout),
    .host_data_lines_oe_low(oe_low), .interrupt_request_low_out(irq_out),
    .interrupt_request_low_oe_low(irq_oe_low), .interrupt_conditions(cond),
    .status_first_channel(st_a), .status_second_channel(st_b),
    .rx_data_first_channel(rx_a), .rx_data_second_channel(rx_b),
    .tx_bit_first_channel(txb[0]), .tx_bit_second_channel(txb[1]),
    .tx_data_first_channel(txd_a), .tx_data_second_channel(txd_b),
    .chan_tx_load(tx_load), .chan_tx_enable(tx_en), .chan_rx_enable(rx_en),
    .serial_out_first_channel(so[0]), .serial_out_second_channel(so[1]),
    .output_port_pins(opins), .output_port_config(ocfg),
    .timer_run(trun), .test_mode(tmode)
  );

  dhp_host_model host (
    .sys_clk(sys_clk), .chip_select_low(cs_low), .write_strobe_low(wr_low),
    .read_strobe_low(rd_low), .register_select_lines(sel),
    .dev_data(dout), .dev_oe_low(oe_low), .data_bus(bus)
  );

  // clock, 40 ns period
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  // xorshift step; low byte feeds the device inputs
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // note the expected byte, then let the host read it
  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    logic ok;
    exp_q.push_back(e);
    host.bus_read(a, ok);
    check(ok, 1'b1);
  endtask

  // sampled while reset is still high
  task automatic check_reset();
    check(opins, PINS_IDLE);
    check(trun, 1'b0);
    check(ocfg, BYTE_CLEAR);
    check(irq_oe_low, 1'b1);
    check({so, tx_en, rx_en}, 6'h30);
    check(tmode, 1'b0);
    check(oe_low, 1'b1);
  endtask

  // a read result appears when the device starts driving; also a timeout
  always @(posedge sys_clk)
  begin
    prev_oe <= oe_low;
    cycles++;
    if (oe_low === 1'b0 && prev_oe === 1'b1)
      check(bus, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    if (tx_load[0] === 1'b1)
      loads[0]++;
    if (tx_load[1] === 1'b1)
      loads[1]++;
    if (cycles == 5000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    logic [7:0] v;
    logic [7:0] port;
    logic [3:0] base;
    repeat (10) @(posedge sys_clk);
    check_reset();
    rst <= 1'b0;
    st_a <= rnd();
    st_b <= rnd();
    rx_a <= rnd();
    rx_b <= rnd();
    // a write lands only after the strobe rises
    v = rnd() | 8'h80;
    fork
      host.bus_write(ADR_PORT_CFG, v);
      begin
        repeat (4) @(posedge sys_clk);
        check(ocfg, BYTE_CLEAR);
      end
    join
    check(ocfg, v);
    // a walking one shows the lane order
    for (int i = 0; i < 8; i++)
    begin
      host.bus_write(ADR_PORT_CFG, 8'h01 << i);
      check(ocfg, 8'h01 << i);
    end
    // strobes without chip select: nothing written, bus left floating
    host.stray(1'b1, ADR_PORT_SET);
    check(opins, PINS_IDLE);
    host.stray(1'b0, ADR_PORT_CFG);
    check(oe_low, 1'b1);
    // readable selects, unmapped and command ones included
    rd_exp(4'h1, st_a);
    rd_exp(4'h9, st_b);
    rd_exp(4'h3, rx_a);
    rd_exp(4'hB, rx_b);
    rd_exp(4'h2, 8'h00);
    rd_exp(4'hE, 8'h00);
    rd_exp(4'hF, 8'h00);
    // set then clear port bits; pins show the complement
    port = rnd();
    v = rnd();
    host.bus_write(ADR_PORT_SET, port);
    host.bus_write(ADR_PORT_CLR, v);
    port = port & ~v;
    check(opins, ~port);
    rd_exp(ADR_PORT_SET, port);
    // each mask bit alone, with the other conditions random
    for (int i = 0; i < 8; i++)
    begin
      host.bus_write(ADR_INT, 8'h01 << i);
      cond <= rnd() | (8'h01 << i);
      repeat (3) @(posedge sys_clk);
      check(irq_oe_low, 1'b0);
      cond <= rnd() & ~(8'h01 << i);
      repeat (3) @(posedge sys_clk);
      check(irq_oe_low, 1'b1);
    end
    check(irq_out, 1'b0);
    rd_exp(ADR_INT, cond);
    // both channels: enable, load a byte, disable with both bits set
    port = rnd();
    txb <= port[1:0];
    for (int ch = 0; ch < 2; ch++)
    begin
      base = ch[0] ? 4'h8 : 4'h0;
      host.bus_write(base | {2'b00, LOC_CMD}, 8'h05);
      check({tx_en[ch], rx_en[ch], so[ch]}, {2'b11, port[ch]});
      v = rnd();
      host.bus_write(base | {2'b00, LOC_DATA}, v);
      check(ch[0] ? txd_b : txd_a, v);
      check(8'(loads[ch]), 8'h01);
      host.bus_write(base | {2'b00, LOC_CMD}, 8'h0F);
      check({tx_en[ch], rx_en[ch], so[ch]}, 3'b001);
    end
    // mode pair: a write steps the pointer, the command points it back
    v = rnd();
    port = rnd();
    host.bus_write({2'b00, LOC_MODE}, v);
    host.bus_write({2'b00, LOC_MODE}, port);
    host.bus_write({2'b00, LOC_CMD}, 8'h10);
    rd_exp({2'b00, LOC_MODE}, v);
    rd_exp({2'b00, LOC_MODE}, port);
    // a second reset in mid-run undoes what the host set up
    host.bus_write(ADR_TIMER, 8'h01);
    host.bus_write(ADR_TEST, 8'h01);
    host.bus_write(ADR_INT, 8'hFF);
    check({trun, tmode}, 2'b11);
    rd_exp(ADR_TEST, 8'h01);
    rd_exp(ADR_TIMER, 8'h01);
    cond <= 8'hFF;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check_reset();
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(irq_oe_low, 1'b1);
    rd_exp(ADR_PORT_SET, BYTE_CLEAR);
    // pointer was left on the second register; reset must bring it back
    v = rnd() | 8'h01;
    host.bus_write({2'b00, LOC_MODE}, v);
    host.bus_write({2'b00, LOC_CMD}, 8'h10);
    rd_exp({2'b00, LOC_MODE}, v);
    final_report();
  end
endmodule
`default_nettype wire
